// ==== verilog/txss_top.sv ====
// Transmit source selector: register slave and pin routing multiplexers.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

// Summary of operation
// - Load-modulation field selects load modulation source
// - Driver field selects both antenna driver sources
// - Constant high follows driver inversion settings
// - Signal-out codes 0..2: tristate, low, high
// - Code 0011 outputs chosen test-bus bit
// - Codes 0100/0101: coder envelope, transmit stream
// - Code 0110 outputs regenerated delayed receiver
// - Code 0111 outputs received serial stream
// - Codes 1000-1010 first group, 1011 reserved
// - Codes 1100-1111 second secure group signals
// - Reset: drivers coder envelope, others tristate
// - Driver inverted per carrier state bits
module txss_top (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Avalon-MM slave.
	input  wire logic [17:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic      [1:0]  avs_response,
	output logic             avs_waitrequest,
	// Internal sources on the same clock.
	input  wire logic        coder_envelope,
	input  wire logic        load_mod_test_sig,
	input  wire logic [7:0]  test_bus,
	input  wire logic        tx_serial_stream,
	input  wire logic        rx_regenerated,
	input  wire logic        rx_serial_stream,
	input  wire logic        demod_comparator,
	input  wire logic        rx_with_carrier,
	input  wire logic        tx_with_carrier,
	input  wire logic        rx_raw_carrier,
	input  wire logic        rx_raw_envelope,
	// Envelope from the pin.
	input  wire logic        external_envelope_input,
	// Routed pins, each with output enable.
	output logic             load_modulation_pin_o,
	output logic             load_modulation_pin_oe,
	output logic             antenna_driver_one_o,
	output logic             antenna_driver_one_oe,
	output logic             antenna_driver_two_o,
	output logic             antenna_driver_two_oe,
	output logic             signal_output_pin_o,
	output logic             signal_output_pin_oe
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed {
		logic [7:0]  tx_source_select;
		logic [7:0]  tx_control;
		logic [7:0]  test_select;
		logic        ack;
		logic [31:0] rdata;
		logic [1:0]  resp;
		logic        lm_o;
		logic        lm_oe;
		logic        d1_o;
		logic        d1_oe;
		logic        d2_o;
		logic        d2_oe;
		logic        so_o;
		logic        so_oe;
	} txss_state_t;

	txss_state_t st_reg;
	txss_state_t st_next;
	logic        ext_env;

	// Envelope pin comes from outside the clock domain.
	txss_sync #(
		.W (1)
	) u_env_sync (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.pin_in    (external_envelope_input),
		.level_out (ext_env)
	);

	// Word index decode, used for reads and writes.
	function automatic logic [1:0] reg_sel(input logic [17:0] a);
		reg_sel = 2'h3;
		if (a[1:0] == 2'h0) begin
			if (a[17:2] == txss_pkg::TX_SOURCE_SELECT_IDX) begin
				reg_sel = 2'h0;
			end else if (a[17:2] == txss_pkg::TX_CONTROL_IDX) begin
				reg_sel = 2'h1;
			end else if (a[17:2] == txss_pkg::TEST_SELECT_IDX) begin
				reg_sel = 2'h2;
			end
		end
	endfunction : reg_sel

	// Driver source decode shared by both antenna drivers.
	function automatic logic drv_level(input logic [1:0] src,
		input logic coder, input logic ext, input logic inv);
		case (src)
			txss_pkg::SRC_CODER:    drv_level = coder ^ inv;
			txss_pkg::SRC_EXTERNAL: drv_level = ext ^ inv;
			txss_pkg::SRC_SPECIAL:  drv_level = 1'b1 ^ inv;
			default:                drv_level = 1'b0;
		endcase
	endfunction : drv_level

	logic [1:0] lm_src;
	logic [1:0] ad_src;
	logic [3:0] so_src;
	logic       d1_inv;
	logic       d2_inv;
	logic [1:0] sel;

	// Field extraction and inversion terms.
	always_comb begin
		lm_src = st_reg.tx_source_select[txss_pkg::LMS_HI:txss_pkg::LMS_LO];
		ad_src = st_reg.tx_source_select[txss_pkg::ADS_HI:txss_pkg::ADS_LO];
		so_src = st_reg.tx_source_select[txss_pkg::SOS_HI:txss_pkg::SOS_LO];
		d1_inv = st_reg.tx_control[txss_pkg::D1_CARRIER]
			? st_reg.tx_control[txss_pkg::D1_INV_ON]
			: st_reg.tx_control[txss_pkg::D1_INV_OFF];
		d2_inv = st_reg.tx_control[txss_pkg::D2_CARRIER]
			? st_reg.tx_control[txss_pkg::D2_INV_ON]
			: st_reg.tx_control[txss_pkg::D2_INV_OFF];
		sel    = reg_sel(avs_address);
	end

	// ************************************************************
	// Next state: bus slave and routing.
	// ************************************************************
	always_comb begin
		st_next     = st_reg;
		st_next.ack = 1'b0;
		// Each access is answered one cycle after it appears.
		if ((avs_read || avs_write) && !st_reg.ack) begin
			st_next.ack   = 1'b1;
			st_next.rdata = '0;
			st_next.resp  = (sel == 2'h3) ? 2'h2 : 2'h0;
			if (avs_write && avs_byteenable[0]) begin
				case (sel)
					2'h0: st_next.tx_source_select = avs_writedata[7:0];
					2'h1: st_next.tx_control = avs_writedata[7:0];
					2'h2: st_next.test_select = avs_writedata[7:0];
					default: st_next.tx_control = st_reg.tx_control;
				endcase
			end
			if (avs_read) begin
				case (sel)
					2'h0: st_next.rdata = {24'h00_0000, st_reg.tx_source_select};
					2'h1: st_next.rdata = {24'h00_0000, st_reg.tx_control};
					2'h2: st_next.rdata = {24'h00_0000, st_reg.test_select};
					default: st_next.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Load modulation pin.
		st_next.lm_oe = (lm_src != txss_pkg::SRC_TRISTATE);
		case (lm_src)
			txss_pkg::SRC_CODER:    st_next.lm_o = coder_envelope;
			txss_pkg::SRC_EXTERNAL: st_next.lm_o = ext_env;
			txss_pkg::SRC_SPECIAL:  st_next.lm_o = load_mod_test_sig;
			default:                st_next.lm_o = 1'b0;
		endcase

		// Antenna drivers.
		st_next.d1_oe = (ad_src != txss_pkg::SRC_TRISTATE);
		st_next.d2_oe = (ad_src != txss_pkg::SRC_TRISTATE);
		st_next.d1_o  = drv_level(ad_src, coder_envelope, ext_env, d1_inv);
		st_next.d2_o  = drv_level(ad_src, coder_envelope, ext_env, d2_inv);

		// Signal output pin.
		st_next.so_oe = 1'b1;
		case (txss_pkg::txss_signal_output_pin_t'(so_src))
			txss_pkg::SO_TRISTATE: begin
				st_next.so_oe = 1'b0;
				st_next.so_o  = 1'b0;
			end
			txss_pkg::SO_LOW:       st_next.so_o = 1'b0;
			txss_pkg::SO_HIGH:      st_next.so_o = 1'b1;
			txss_pkg::SO_TEST_BUS:  st_next.so_o = test_bus[st_reg.test_select[
				txss_pkg::TBB_HI:txss_pkg::TBB_LO]];
			txss_pkg::SO_CODER:     st_next.so_o = coder_envelope;
			txss_pkg::SO_TX_STREAM: st_next.so_o = tx_serial_stream;
			// Valid only while software keeps the receiver active.
			txss_pkg::SO_RX_REGEN:  st_next.so_o = rx_regenerated;
			txss_pkg::SO_RX_STREAM: st_next.so_o = rx_serial_stream;
			txss_pkg::SO_G1_RX:     st_next.so_o = rx_serial_stream;
			txss_pkg::SO_G1_TX:     st_next.so_o = tx_serial_stream;
			txss_pkg::SO_G1_COMP:   st_next.so_o = demod_comparator;
			txss_pkg::SO_G2_RX:     st_next.so_o = rx_with_carrier;
			txss_pkg::SO_G2_TX:     st_next.so_o = tx_with_carrier;
			txss_pkg::SO_G2_RXRAW:  st_next.so_o = rx_raw_carrier;
			txss_pkg::SO_G2_ENV:    st_next.so_o = rx_raw_envelope;
			default:                st_next.so_o = 1'b0; // Reserved code drives low.
		endcase
	end

	// State register with documented reset values.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_reg                  <= '0;
			st_reg.tx_source_select <= txss_pkg::TX_SOURCE_SELECT_RST;
			st_reg.tx_control       <= txss_pkg::TX_CONTROL_RST;
			st_reg.test_select      <= txss_pkg::TEST_SELECT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops.
	assign avs_readdata           = st_reg.rdata;
	assign avs_response           = st_reg.resp;
	assign avs_waitrequest        = ~st_reg.ack;
	assign load_modulation_pin_o  = st_reg.lm_o;
	assign load_modulation_pin_oe = st_reg.lm_oe;
	assign antenna_driver_one_o   = st_reg.d1_o;
	assign antenna_driver_one_oe  = st_reg.d1_oe;
	assign antenna_driver_two_o   = st_reg.d2_o;
	assign antenna_driver_two_oe  = st_reg.d2_oe;
	assign signal_output_pin_o    = st_reg.so_o;
	assign signal_output_pin_oe   = st_reg.so_oe;

	// ************************************************************
	// Assertions.
	// ************************************************************
	property p_lm_tristate;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(lm_src) == txss_pkg::SRC_TRISTATE |-> !load_modulation_pin_oe;
	endproperty
	a_lm_tristate: assert property (p_lm_tristate)
		else $error("load modulation pin not released");

	property p_drv_high;
		@(posedge ref_clk) disable iff (sys_rst)
		(ad_src == txss_pkg::SRC_SPECIAL) ##1 $stable(st_reg.tx_control)
		|-> antenna_driver_one_o == !$past(d1_inv);
	endproperty
	a_drv_high: assert property (p_drv_high)
		else $error("driver one high level wrong");

	property p_drv_oe;
		@(posedge ref_clk) disable iff (sys_rst)
		!$past(sys_rst) |-> {st_reg.d1_oe, st_reg.d2_oe} == {2{$past(ad_src) != '0}};
	endproperty
	a_drv_oe: assert property (p_drv_oe)
		else $error("driver enables differ");

	property p_so_tristate;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(so_src) == 4'h0 |-> !signal_output_pin_oe;
	endproperty
	a_so_tristate: assert property (p_so_tristate)
		else $error("signal output not released");

	property p_so_high;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(so_src) == 4'h2 |-> signal_output_pin_o && signal_output_pin_oe;
	endproperty
	a_so_high: assert property (p_so_high)
		else $error("signal output not high");

	property p_so_coder;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(so_src) == 4'h4 |-> signal_output_pin_o == $past(coder_envelope);
	endproperty
	a_so_coder: assert property (p_so_coder)
		else $error("signal output not coder envelope");

	property p_so_rx;
		@(posedge ref_clk) disable iff (sys_rst)
		$past(so_src) == 4'h7 |-> signal_output_pin_o == $past(rx_serial_stream);
	endproperty
	a_so_rx: assert property (p_so_rx)
		else $error("signal output not receive stream");

	property p_write_applies;
		@(posedge ref_clk) disable iff (sys_rst)
		avs_write && avs_byteenable[0] && !st_reg.ack && sel == 2'h0
		|=> st_reg.tx_source_select == $past(avs_writedata[7:0]);
	endproperty
	a_write_applies: assert property (p_write_applies)
		else $error("selection write not applied");

	property p_ack_one;
		@(posedge ref_clk) disable iff (sys_rst)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("waitrequest low too long");

endmodule : txss_top

// ==== shared/txss_pkg.sv ====
// Package of offsets, field layouts and reset values for the source selector.
package txss_pkg;

	// ************************************************************
	// Register map.
	// ************************************************************
	// Printed offset 0x6306 is not a multiple of four, so it is an index.
	localparam logic [15:0] TX_SOURCE_SELECT_IDX = 16'h6306;
	localparam logic [15:0] TX_CONTROL_IDX       = 16'h6304;
	localparam logic [15:0] TEST_SELECT_IDX      = 16'h6310;
	localparam int          ADDR_W               = 18;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int LMS_HI  = 7;
	localparam int LMS_LO  = 6;
	localparam int ADS_HI  = 5;
	localparam int ADS_LO  = 4;
	localparam int SOS_HI  = 3;
	localparam int SOS_LO  = 0;
	localparam int D2_INV_ON  = 7;
	localparam int D1_INV_ON  = 6;
	localparam int D2_INV_OFF = 5;
	localparam int D1_INV_OFF = 4;
	localparam int D2_CARRIER = 1;
	localparam int D1_CARRIER = 0;
	localparam int TBB_HI  = 2;
	localparam int TBB_LO  = 0;
	localparam int TSC_HI  = 5;
	localparam int TSC_LO  = 4;

	// ************************************************************
	// Reset values.
	// ************************************************************
	localparam logic [7:0] TX_SOURCE_SELECT_RST = 8'h10;
	localparam logic [7:0] TX_CONTROL_RST       = 8'h80;
	localparam logic [7:0] TEST_SELECT_RST      = 8'h00;

	// ************************************************************
	// Source codes.
	// ************************************************************
	localparam logic [1:0] SRC_TRISTATE = 2'h0;
	localparam logic [1:0] SRC_CODER    = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	localparam logic [1:0] SRC_SPECIAL  = 2'h3;

	typedef enum logic [3:0] {
		SO_TRISTATE  = 4'b0000,
		SO_LOW       = 4'b0001,
		SO_HIGH      = 4'b0010,
		SO_TEST_BUS  = 4'b0011,
		SO_CODER     = 4'b0100,
		SO_TX_STREAM = 4'b0101,
		SO_RX_REGEN  = 4'b0110,
		SO_RX_STREAM = 4'b0111,
		SO_G1_RX     = 4'b1000,
		SO_G1_TX     = 4'b1001,
		SO_G1_COMP   = 4'b1010,
		SO_G1_RSVD   = 4'b1011,
		SO_G2_RX     = 4'b1100,
		SO_G2_TX     = 4'b1101,
		SO_G2_RXRAW  = 4'b1110,
		SO_G2_ENV    = 4'b1111
	} txss_signal_output_pin_t;

endpackage : txss_pkg

// ==== verilog/txss_sync.sv ====
// Three-stage pin synchroniser that accepts a change when stages agree.
`timescale 1ns/1ps
module txss_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Raw pins and filtered levels.
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} txss_sync_st_t;

	txss_sync_st_t st_reg;
	txss_sync_st_t st_next;

	// Stage one is read only by stage two; the level moves when two and three agree.
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = pin_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < W; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.lvl[i] = st_reg.s3[i];
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level_out = st_reg.lvl;

endmodule : txss_sync

// ==== tb/txss_far_side.sv ====
// Far-side model: envelope source pin and secure IC data sampler.
`timescale 1ns/1ps
module txss_far_side (
	// Clock.
	input  wire logic ref_clk,
	// Bench request and envelope pin to the design.
	input  wire logic env_level,
	output logic      external_envelope_input,
	// Signal output pin as the secure IC sees it.
	input  wire logic signal_output_pin_o,
	input  wire logic signal_output_pin_oe,
	output logic      sio_level = 1'b0
);
	// The envelope pin follows the level the bench asks for.
	assign external_envelope_input = env_level;

	// Secure IC samples data; a released line toggles its level every clock.
	always_ff @(posedge ref_clk) begin
		if (signal_output_pin_oe) begin
			sio_level <= signal_output_pin_o;
		end else begin
			sio_level <= ~sio_level;
		end
	end
endmodule : txss_far_side

// ==== tb/tb_txss_top.sv ====
// Self-checking bench for the transmit source selector.
`timescale 1ns/1ps
module tb_txss_top;
	// ************************************************************
	// Signals and constants.
	// ************************************************************
	localparam logic [17:0] SEL_A = {txss_pkg::TX_SOURCE_SELECT_IDX, 2'b00};
	localparam logic [17:0] CTL_A = {txss_pkg::TX_CONTROL_IDX, 2'b00};
	localparam logic [17:0] TST_A = {txss_pkg::TEST_SELECT_IDX, 2'b00};
	localparam int SOIDX [16] = '{0, 0, 1, 4, 2, 12, 13, 14, 14, 12, 15, 0,
		16, 17, 18, 19};
	localparam logic [7:0] CTLS [4] = '{8'h80, 8'h43, 8'h30, 8'hC3};
	logic        ref_clk        = 1'b0;
	logic        sys_rst        = 1'b1;
	logic [17:0] avs_address    = 18'h0_0000;
	logic        avs_read       = 1'b0;
	logic        avs_write      = 1'b0;
	logic [31:0] avs_writedata  = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic [1:0]  avs_response;
	logic        avs_waitrequest;
	logic [18:0] src            = 19'h0_0001;
	wire         ext_pin;
	wire  [7:0]  pin;
	wire         sio;
	int          n_fail         = 0;
	int          num_checks     = 0;

	// Clock at 20 MHz.
	always #25 ref_clk = ~ref_clk;

	// Design under test; pin holds o/oe pairs of the four routed pins.
	txss_top u_txss_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
		.coder_envelope(src[0]), .load_mod_test_sig(src[1]),
		.test_bus(src[9:2]), .tx_serial_stream(src[10]),
		.rx_regenerated(src[11]), .rx_serial_stream(src[12]),
		.demod_comparator(src[13]), .rx_with_carrier(src[14]),
		.tx_with_carrier(src[15]), .rx_raw_carrier(src[16]),
		.rx_raw_envelope(src[17]), .external_envelope_input(ext_pin),
		.load_modulation_pin_o(pin[7]), .load_modulation_pin_oe(pin[6]),
		.antenna_driver_one_o(pin[5]), .antenna_driver_one_oe(pin[4]),
		.antenna_driver_two_o(pin[3]), .antenna_driver_two_oe(pin[2]),
		.signal_output_pin_o(pin[1]), .signal_output_pin_oe(pin[0]));

	// Far side of the routed pins.
	txss_far_side u_txss_far_side (.ref_clk(ref_clk), .env_level(src[18]),
		.external_envelope_input(ext_pin), .signal_output_pin_o(pin[1]),
		.signal_output_pin_oe(pin[0]), .sio_level(sio));

	// ************************************************************
	// Shared tasks.
	// ************************************************************
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [17:0] a,
		input logic [7:0] d, output logic [31:0] q, output logic [1:0] r);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 50) begin
			n_fail++;
			stop_test();
		end
		q = avs_readdata;
		r = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
	endtask : wr

	task automatic rd_chk(input logic [17:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 8'h00, q, r);
		check(q, e);
		check(r, er);
	endtask : rd_chk

	// Expected driver pair {o, oe} for a two-bit source code.
	function automatic logic [1:0] drv(input logic [1:0] c,
		input logic inv);
		logic b;
		b = (c == 2'h1) ? src[0] : (c == 2'h2) ? src[18] : 1'b1;
		return (c == 2'h0) ? 2'b00 : {b ^ inv, 1'b1};
	endfunction : drv

	// Programs the selection, then walks five source patterns.
	task automatic sweep(input logic [7:0] sel, input logic [7:0] ctl);
		logic [20:0] v;
		logic [1:0]  e;
		int          p;
		int          k;
		logic [18:0] nx;
		wr(CTL_A, ctl);
		wr(SEL_A, sel);
		#1;
		check(pin[6], sel[7:6] != 2'h0);
		for (p = 0; p < 5; p++) begin
			@(posedge ref_clk);
			for (k = 0; k < 19; k++) begin
				nx[k] = 1'(((k + 1) >> p) & 1);
			end
			src <= nx;
			repeat (6) @(posedge ref_clk);
			#1;
			v = {src, 2'b10};
			e = (sel[7:6] == 2'h3) ? {src[1], 1'b1} : drv(sel[7:6], 1'b0);
			check(pin[7:6], e);
			e = drv(sel[5:4], ctl[0] ? ctl[6] : ctl[4]);
			check(pin[5:4], e);
			e = drv(sel[5:4], ctl[1] ? ctl[7] : ctl[5]);
			check(pin[3:2], e);
			k = SOIDX[sel[3:0]] + ((sel[3:0] == 4'h3) ? 5 : 0);
			e = {v[k], sel[3:0] != 4'h0};
			check(pin[1:0], e);
			// The secure IC must see the routed level while the pin drives.
			if (e[0]) check(sio, e[1]);
		end
	endtask : sweep

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task automatic t_reset();
		#1;
		check(pin, 8'h3C);
		rd_chk(SEL_A, 32'h0000_0010, 2'b00);
		rd_chk(CTL_A, 32'h0000_0080, 2'b00);
		rd_chk(TST_A, 32'h0000_0000, 2'b00);
	endtask : t_reset

	task automatic t_regs();
		wr(SEL_A, 8'hA5);
		rd_chk(SEL_A, 32'h0000_00A5, 2'b00);
		rd_chk(18'h0_0000, 32'h0000_0000, 2'b10);
		wr(TST_A, 8'h05);
		rd_chk(TST_A, 32'h0000_0005, 2'b00);
	endtask : t_regs

	task automatic t_routes();
		int c;
		int k;
		for (c = 0; c < 4; c++) begin
			sweep({c[1:0], 6'h10}, 8'h80);
			for (k = 0; k < 4; k++) begin
				sweep({2'h0, c[1:0], 4'h0}, CTLS[k]);
			end
		end
		for (c = 0; c < 16; c++) begin
			sweep({4'h1, c[3:0]}, 8'h80);
		end
	endtask : t_routes

	// Main sequence: reset for four cycles, then the scenarios.
	initial begin
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_regs();
		t_routes();
		stop_test();
	end
endmodule : tb_txss_top
